// *** verilog/ddr_sep_io_sram_port.sv ***
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Address and selects taken on true-clock rise
// - Write data taken on both clock rises
// - Echo clocks aligned with read data changes
// - Echo clocks run continuously, even when idle
// - DLL disable low bypasses and clears lock
// - DLL enable high starts lock; host waits
// - DLL off gives one-cycle read latency
// - Read valid marks driven data, echo aligned
// - Address registered only when selected
// - Write data width follows configuration
// - Read data driven only for reads
// - Write select low starts write cycle
// - Read select low starts read cycle
// - DLL on: first beat two cycles later
// - Byte mask low writes that byte
module ddr_sep_io_sram_port
   import sram_port_pkg::*;
#(
   parameter bit CONFIG_X36 = 1'b1
)(
   input  wire logic                                clk,
   input  wire logic                                rst,
   input  wire logic                                inClockTrue,
   input  wire logic                                inClockComp,
   input  wire logic                                dllEnable,
   input  wire logic                                readSelN,
   input  wire logic                                writeSelN,
   input  wire logic [sram_port_pkg::MAX_ADDR_W-1:0] sync_address_bus,
   input  wire logic [sram_port_pkg::MAX_DATA_W-1:0] write_data_in,
   input  wire logic [sram_port_pkg::MAX_MASK_W-1:0] byte_write_mask_n,
   output logic      [sram_port_pkg::MAX_DATA_W-1:0] read_data_out,
   output logic                                     read_data_oe,
   output logic                                     read_valid_out,
   output logic                                     echo_clock_true,
   output logic                                     echo_clock_comp,
   output logic                                     dllLocked
);
   import sram_port_pkg::*;

   // ==========================================================
   // Configuration
   // ==========================================================
   localparam int DATA_W = CONFIG_X36 ? X36_DATA_W : X18_DATA_W;
   localparam int ADDR_W = CONFIG_X36 ? X36_ADDR_W : X18_ADDR_W;
   localparam int MASK_W = DATA_W / BYTE_W;
   localparam int WORD_W = ADDR_W + BEAT_W;
   localparam int DEPTH  = 1 << WORD_W;

   link_edges_if edges ();

   link_sampler u_sampler (
      .clk               (clk),
      .rst               (rst),
      .inClockTrue       (inClockTrue),
      .inClockComp       (inClockComp),
      .dllEnable         (dllEnable),
      .readSelN          (readSelN),
      .writeSelN         (writeSelN),
      .sync_address_bus  (sync_address_bus),
      .write_data_in     (write_data_in),
      .byte_write_mask_n (byte_write_mask_n),
      .edges             (edges.sampler)
   );

   logic [DATA_W-1:0] memArray [DEPTH];

   logic [ADDR_W-1:0] cmdAddr;
   assign cmdAddr = edges.addr[ADDR_W-1:0];

   // ==========================================================
   // DLL lock tracking
   // ==========================================================
   logic [LOCK_CNT_W-1:0] lockCnt_reg;
   logic [LOCK_CNT_W-1:0] lockCnt_next;
   logic                  dllLocked_reg;
   logic                  dllLocked_next;

   // Lock counts input clock rises so it tracks the host's rate
   always_comb begin
      lockCnt_next   = lockCnt_reg;
      dllLocked_next = dllLocked_reg;
      if (!edges.dllEnable) begin
         lockCnt_next   = '0;
         dllLocked_next = 1'b0;
      end else if (edges.kRise && !dllLocked_reg) begin
         if (lockCnt_reg == LOCK_CNT_W'(LOCK_KCYCLES - 1)) begin
            dllLocked_next = 1'b1;
         end else begin
            lockCnt_next = lockCnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lockCnt_reg   <= '0;
         dllLocked_reg <= 1'b0;
      end else begin
         lockCnt_reg   <= lockCnt_next;
         dllLocked_reg <= dllLocked_next;
      end
   end

   // ==========================================================
   // Write path: late write, four beats
   // ==========================================================
   logic              wrPendV_reg,  wrPendV_next;
   logic [ADDR_W-1:0] wrPendA_reg,  wrPendA_next;
   logic [ADDR_W-1:0] wrBase_reg,   wrBase_next;
   beat_e             wrBeat_reg,   wrBeat_next;
   logic              wrEn;
   logic [WORD_W-1:0] wrIdx;

   always_comb begin
      wrPendV_next = wrPendV_reg;
      wrPendA_next = wrPendA_reg;
      wrBase_next  = wrBase_reg;
      wrBeat_next  = wrBeat_reg;
      wrEn         = 1'b0;
      wrIdx        = {wrBase_reg, 2'b00};
      if (edges.kRise) begin
         if (wrBeat_reg == BEAT_IDLE && wrPendV_reg) begin
            wrEn        = 1'b1;
            wrIdx       = {wrPendA_reg, 2'b00};
            wrBase_next = wrPendA_reg;
            wrBeat_next = BEAT_SECND;
         end else if (wrBeat_reg == BEAT_THIRD) begin
            wrEn        = 1'b1;
            wrIdx       = {wrBase_reg, 2'b10};
            wrBeat_next = BEAT_FOURTH;
         end
         wrPendV_next = ~edges.writeSelN;
         if (!edges.writeSelN) begin
            wrPendA_next = cmdAddr;
         end
      end else if (edges.kcRise) begin
         if (wrBeat_reg == BEAT_SECND) begin
            wrEn        = 1'b1;
            wrIdx       = {wrBase_reg, 2'b01};
            wrBeat_next = BEAT_THIRD;
         end else if (wrBeat_reg == BEAT_FOURTH) begin
            wrEn        = 1'b1;
            wrIdx       = {wrBase_reg, 2'b11};
            wrBeat_next = BEAT_IDLE;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPendV_reg <= 1'b0;
         wrPendA_reg <= '0;
         wrBase_reg  <= '0;
         wrBeat_reg  <= BEAT_IDLE;
      end else begin
         wrPendV_reg <= wrPendV_next;
         wrPendA_reg <= wrPendA_next;
         wrBase_reg  <= wrBase_next;
         wrBeat_reg  <= wrBeat_next;
      end
   end

   // Per-lane array write in one process, so the array has one writer
   // Array has no reset, so unwritten words read as unknown
   always_ff @(posedge clk) begin
      for (int b = 0; b < MASK_W; b++) begin
         if (wrEn && !edges.maskN[b]) begin
            memArray[wrIdx][b*BYTE_W +: BYTE_W] <=
               edges.data[b*BYTE_W +: BYTE_W];
         end
      end
   end

   // ==========================================================
   // Read path: command pipeline and burst out
   // ==========================================================
   logic              rdV1_reg, rdV1_next;
   logic              rdV2_reg, rdV2_next;
   logic [ADDR_W-1:0] rdA1_reg, rdA1_next;
   logic [ADDR_W-1:0] rdA2_reg, rdA2_next;
   logic [ADDR_W-1:0] rdBase_reg, rdBase_next;
   beat_e             rdBeat_reg, rdBeat_next;
   logic [DATA_W-1:0] rdData_reg, rdData_next;
   logic              rdValid_reg, rdValid_next;
   logic              echoT_reg, echoT_next;
   logic              echoC_reg, echoC_next;
   logic              launchV;
   logic [ADDR_W-1:0] launchA;

   always_comb begin
      rdV1_next    = rdV1_reg;
      rdV2_next    = rdV2_reg;
      rdA1_next    = rdA1_reg;
      rdA2_next    = rdA2_reg;
      rdBase_next  = rdBase_reg;
      rdBeat_next  = rdBeat_reg;
      rdData_next  = rdData_reg;
      rdValid_next = rdValid_reg;
      // Echo follows the sampled clocks, same stage as the data
      echoT_next   = edges.kLevel;
      echoC_next   = edges.kcLevel;
      // Short path when DLL is off, two stages otherwise
      launchV      = edges.dllEnable ? rdV2_reg : rdV1_reg;
      launchA      = edges.dllEnable ? rdA2_reg : rdA1_reg;
      if (edges.kRise) begin
         rdV1_next = ~edges.readSelN;
         rdV2_next = rdV1_reg;
         rdA2_next = rdA1_reg;
         if (!edges.readSelN) begin
            rdA1_next = cmdAddr;
         end
         if (launchV) begin
            rdData_next  = memArray[{launchA, 2'b00}];
            rdBase_next  = launchA;
            rdBeat_next  = BEAT_SECND;
            rdValid_next = 1'b1;
         end else if (rdBeat_reg == BEAT_THIRD) begin
            rdData_next = memArray[{rdBase_reg, 2'b10}];
            rdBeat_next = BEAT_FOURTH;
         end else begin
            rdValid_next = 1'b0;
         end
      end else if (edges.kcRise) begin
         if (rdBeat_reg == BEAT_SECND) begin
            rdData_next = memArray[{rdBase_reg, 2'b01}];
            rdBeat_next = BEAT_THIRD;
         end else if (rdBeat_reg == BEAT_FOURTH) begin
            rdData_next = memArray[{rdBase_reg, 2'b11}];
            rdBeat_next = BEAT_IDLE;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdV1_reg    <= 1'b0;
         rdV2_reg    <= 1'b0;
         rdA1_reg    <= '0;
         rdA2_reg    <= '0;
         rdBase_reg  <= '0;
         rdBeat_reg  <= BEAT_IDLE;
         rdData_reg  <= '0;
         rdValid_reg <= 1'b0;
         echoT_reg   <= 1'b0;
         echoC_reg   <= 1'b0;
      end else begin
         rdV1_reg    <= rdV1_next;
         rdV2_reg    <= rdV2_next;
         rdA1_reg    <= rdA1_next;
         rdA2_reg    <= rdA2_next;
         rdBase_reg  <= rdBase_next;
         rdBeat_reg  <= rdBeat_next;
         rdData_reg  <= rdData_next;
         rdValid_reg <= rdValid_next;
         echoT_reg   <= echoT_next;
         echoC_reg   <= echoC_next;
      end
   end

   // ==========================================================
   // Outputs, all from flops
   // ==========================================================
   assign read_data_out   = MAX_DATA_W'(rdData_reg);
   assign read_data_oe    = rdValid_reg;
   assign read_valid_out  = rdValid_reg;
   assign echo_clock_true = echoT_reg;
   assign echo_clock_comp = echoC_reg;
   assign dllLocked       = dllLocked_reg;

endmodule : ddr_sep_io_sram_port
`default_nettype wire

// *** verilog/sram_port_pkg.sv ***
package sram_port_pkg;

   // ==========================================================
   // Configuration widths
   // ==========================================================
   localparam int X36_DATA_W = 36;
   localparam int X18_DATA_W = 18;
   localparam int X36_ADDR_W = 17;
   localparam int X18_ADDR_W = 18;
   localparam int BYTE_W     = 9;
   localparam int MAX_DATA_W = 36;
   localparam int MAX_MASK_W = 4;
   localparam int MAX_ADDR_W = 18;
   localparam int BEAT_W     = 2;

   // ==========================================================
   // Latency and timing
   // ==========================================================
   localparam int LAT_DLL_ON   = 2;
   localparam int LAT_DLL_OFF  = 1;
   localparam int CLK_MHZ      = 10;
   localparam int DLL_OFF_KMAX_MHZ = 167;
   // Lock time in input clock periods; no figure given, plain default
   localparam int LOCK_KCYCLES = 1024;
   localparam int LOCK_CNT_W   = 11;

   // Burst beat tracker: which beat comes next
   typedef enum logic [1:0] {
      BEAT_IDLE  = 2'b00,
      BEAT_SECND = 2'b01,
      BEAT_THIRD = 2'b10,
      BEAT_FOURTH = 2'b11
   } beat_e;

endpackage : sram_port_pkg

// *** verilog/link_edges_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface link_edges_if;
   import sram_port_pkg::*;
   logic                  kRise;
   logic                  kcRise;
   logic                  kLevel;
   logic                  kcLevel;
   logic                  dllEnable;
   logic                  readSelN;
   logic                  writeSelN;
   logic [MAX_ADDR_W-1:0] addr;
   logic [MAX_DATA_W-1:0] data;
   logic [MAX_MASK_W-1:0] maskN;

   modport sampler (output kRise, kcRise, kLevel, kcLevel, dllEnable,
                    readSelN, writeSelN, addr, data, maskN);
   modport core    (input kRise, kcRise, kLevel, kcLevel, dllEnable,
                    readSelN, writeSelN, addr, data, maskN);
endinterface : link_edges_if
`default_nettype wire

// *** verilog/link_sampler.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_sampler
   import sram_port_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  inClockTrue,
   input  wire logic                  inClockComp,
   input  wire logic                  dllEnable,
   input  wire logic                  readSelN,
   input  wire logic                  writeSelN,
   input  wire logic [MAX_ADDR_W-1:0] sync_address_bus,
   input  wire logic [MAX_DATA_W-1:0] write_data_in,
   input  wire logic [MAX_MASK_W-1:0] byte_write_mask_n,
   link_edges_if.sampler              edges
);
   import sram_port_pkg::*;

   localparam int VEC_W = 5 + MAX_ADDR_W + MAX_DATA_W + MAX_MASK_W;

   // ==========================================================
   // Two-stage synchroniser, all pins together
   // ==========================================================
   logic [VEC_W-1:0] pinVec;
   logic [VEC_W-1:0] meta_reg;
   logic [VEC_W-1:0] meta_next;
   logic [VEC_W-1:0] sync_reg;
   logic [VEC_W-1:0] sync_next;
   logic [1:0]       prev_reg;
   logic [1:0]       prev_next;

   // Whole bus shares one latency so data stays aligned to its edge
   always_comb begin
      pinVec    = {inClockTrue, inClockComp, dllEnable, readSelN,
                   writeSelN, sync_address_bus, write_data_in,
                   byte_write_mask_n};
      meta_next = pinVec;
      sync_next = meta_reg;
      prev_next = sync_reg[VEC_W-1 -: 2];
   end

   // Selects idle high after reset so no command is seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= {2'b00, 3'b011, {(VEC_W-5){1'b0}}};
         sync_reg <= {2'b00, 3'b011, {(VEC_W-5){1'b0}}};
         prev_reg <= 2'b00;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
         prev_reg <= prev_next;
      end
   end

   // Edge pulses from the settled stage only
   assign edges.kLevel    = sync_reg[VEC_W-1];
   assign edges.kcLevel   = sync_reg[VEC_W-2];
   assign edges.kRise     = sync_reg[VEC_W-1] & ~prev_reg[1];
   assign edges.kcRise    = sync_reg[VEC_W-2] & ~prev_reg[0];
   assign edges.dllEnable = sync_reg[VEC_W-3];
   assign edges.readSelN  = sync_reg[VEC_W-4];
   assign edges.writeSelN = sync_reg[VEC_W-5];
   assign edges.addr      = sync_reg[MAX_DATA_W+MAX_MASK_W +: MAX_ADDR_W];
   assign edges.data      = sync_reg[MAX_MASK_W +: MAX_DATA_W];
   assign edges.maskN     = sync_reg[MAX_MASK_W-1:0];

endmodule : link_sampler
`default_nettype wire

// *** test/sram_port_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module sram_port_chk #(
   parameter int KCLK = 8
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic inClockTrue,
   input wire logic inClockComp,
   input wire logic dllEnable,
   input wire logic readSelN,
   input wire logic read_data_oe,
   input wire logic read_valid_out,
   input wire logic echo_clock_true,
   input wire logic echo_clock_comp,
   input wire logic dllLocked
);
   import sram_port_pkg::*;
   localparam int LOCK_LO = LOCK_KCYCLES * KCLK - 12;
   localparam int LOCK_HI = LOCK_KCYCLES * KCLK + 18;
   logic [3:0]  upCnt_reg,   upCnt_next;
   logic [5:0]  idleCnt_reg, idleCnt_next;
   logic [13:0] lockCnt_reg, lockCnt_next;
   logic        kPrev_reg;

   // ==========================================================
   // Helper counters
   // ==========================================================
   // Saturate, so a long idle spell never wraps into a false pass
   always_comb begin
      upCnt_next   = upCnt_reg + {3'h0, upCnt_reg != 4'hf};
      idleCnt_next = (inClockTrue && !kPrev_reg && !readSelN) ? 6'h0
                   : idleCnt_reg + {5'h0, idleCnt_reg != 6'h3f};
      lockCnt_next = !dllEnable ? 14'h0
                   : lockCnt_reg + {13'h0, lockCnt_reg != 14'h3fff};
   end
   // Registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         upCnt_reg   <= 4'h0;
         idleCnt_reg <= 6'h3f;
         lockCnt_reg <= 14'h0;
         kPrev_reg   <= 1'b0;
      end else begin
         upCnt_reg   <= upCnt_next;
         idleCnt_reg <= idleCnt_next;
         lockCnt_reg <= lockCnt_next;
         kPrev_reg   <= inClockTrue;
      end
   end

   // ==========================================================
   // Properties
   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence readOn;  $rose(inClockTrue) && !readSelN && dllEnable;  endsequence
   sequence readOff; $rose(inClockTrue) && !readSelN && !dllEnable; endsequence
   sequence beatZero; read_valid_out && $rose(echo_clock_true); endsequence
   sequence burstBody; read_valid_out[*8] ##8 read_valid_out; endsequence
   sequence lowRun; !dllEnable[*6]; endsequence

   echo_true_a: assert property (
      upCnt_reg > 4'h5 |-> echo_clock_true == $past(inClockTrue, 3))
      else $error("echo true clock off its input");
   echo_comp_a: assert property (
      upCnt_reg > 4'h5 |-> echo_clock_comp == $past(inClockComp, 3))
      else $error("echo comp clock off its input");
   valid_enable_a: assert property (
      read_data_oe == read_valid_out)
      else $error("read enable differs from valid");
   valid_align_a: assert property (
      $changed(read_valid_out) |-> $rose(echo_clock_true))
      else $error("valid moved off an echo rise");
   read_dll_on_a: assert property (
      readOn |-> ##19 beatZero)
      else $error("first beat late or early, dll on");
   read_dll_off_a: assert property (
      readOff |-> ##11 beatZero)
      else $error("first beat late or early, dll off");
   burst_hold_a: assert property (
      $rose(read_valid_out) |-> burstBody)
      else $error("burst shorter than two cycles");
   read_only_a: assert property (
      idleCnt_reg > 6'd40 |-> !read_valid_out)
      else $error("valid without a read");
   dll_bypass_a: assert property (
      lowRun |-> !dllLocked)
      else $error("lock kept while dll disabled");
   lock_window_a: assert property (
      $rose(dllLocked) |-> lockCnt_reg >= LOCK_LO && lockCnt_reg <= LOCK_HI)
      else $error("lock outside its window");
   lock_due_a: assert property (
      lockCnt_reg == LOCK_HI |-> dllLocked)
      else $error("lock never came");
endmodule : sram_port_chk

bind ddr_sep_io_sram_port sram_port_chk i_chk (
   .clk(clk), .rst(rst), .inClockTrue(inClockTrue),
   .inClockComp(inClockComp), .dllEnable(dllEnable), .readSelN(readSelN),
   .read_data_oe(read_data_oe), .read_valid_out(read_valid_out),
   .echo_clock_true(echo_clock_true), .echo_clock_comp(echo_clock_comp),
   .dllLocked(dllLocked));
`default_nettype wire

// *** test/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic                                 clk,
   output var  logic                                 kTrue,
   output var  logic                                 kComp,
   output var  logic                                 readSelN,
   output var  logic                                 writeSelN,
   output var  logic [sram_port_pkg::MAX_ADDR_W-1:0] addr,
   output var  logic [sram_port_pkg::MAX_DATA_W-1:0] data,
   output var  logic [sram_port_pkg::MAX_MASK_W-1:0] maskN,
   output var  logic [2:0]                           phase
);
   import sram_port_pkg::*;
   typedef struct packed {
      logic                    rd;
      logic                    wr;
      logic [MAX_ADDR_W-1:0]   a;
      logic [4*MAX_DATA_W-1:0] d;
      logic [4*MAX_MASK_W-1:0] m;
   } hostCmd_s;
   hostCmd_s pend, cmd0, cmd1, cmd2;
   logic     pendValid;

   // ==========================================================
   // Command entry
   // ==========================================================
   // Returns once the command sits on the pins for the next K rise
   task automatic post(input logic rd, input logic wr,
      input logic [MAX_ADDR_W-1:0] a, input logic [4*MAX_DATA_W-1:0] d,
      input logic [4*MAX_MASK_W-1:0] m);
      while (phase != 3'd3) begin
         @(posedge clk);
         #2;
      end
      pend      = '{rd, wr, a, d, m};
      pendValid = 1'b1;
      wait (!pendValid);
   endtask : post

   // Idle data lines scramble so a stale beat is never re-read
   task automatic beat(input hostCmd_s c, input int i);
      if (c.wr) begin
         data  = c.d[i*MAX_DATA_W +: MAX_DATA_W];
         maskN = c.m[i*MAX_MASK_W +: MAX_MASK_W];
      end else begin
         data  = ~data;
         maskN = ~maskN;
      end
   endtask : beat

   // ==========================================================
   // Pin driver, K period of eight clk
   // ==========================================================
   // Data moves midway between sampling edges for margin
   initial begin
      phase     = 3'd7;
      kTrue     = 1'b0;
      kComp     = 1'b1;
      readSelN  = 1'b1;
      writeSelN = 1'b1;
      addr      = '0;
      data      = '0;
      maskN     = '1;
      pendValid = 1'b0;
      cmd0      = '0;
      cmd1      = '0;
      forever begin
         @(posedge clk);
         #1;
         phase = phase + 3'd1;
         kTrue = phase < 3'd4;
         kComp = !kTrue;
         if (phase == 3'd4) begin
            cmd2      = cmd1;
            cmd1      = cmd0;
            cmd0      = pendValid ? pend : '0;
            pendValid = 1'b0;
            readSelN  = !cmd0.rd;
            writeSelN = !cmd0.wr;
            addr      = (cmd0.rd || cmd0.wr) ? cmd0.a : ~addr;
         end else if (phase == 3'd6) begin
            beat(cmd1.wr ? cmd1 : cmd2, cmd1.wr ? 0 : 2);
         end else if (phase == 3'd2) begin
            beat(cmd1.wr ? cmd1 : cmd2, cmd1.wr ? 1 : 3);
         end
      end
   end
endmodule : host_model
`default_nettype wire

// *** test/ddr_sep_io_sram_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module ddr_sep_io_sram_port_tb;
   import sram_port_pkg::*;
   localparam logic [17:0] ADDR_A = 18'h01234;
   localparam logic [17:0] ADDR_B = 18'h00ab0;
   logic          clk;
   logic          rst;
   logic          dllEnable;
   logic          kTrue;
   logic          kComp;
   logic          readSelN;
   logic          writeSelN;
   logic [17:0]   addr;
   logic [35:0]   wData;
   logic [35:0]   rData;
   logic [3:0]    maskN;
   logic [2:0]    phase;
   logic          rValid;
   logic          dllLocked;
   logic [143:0]  memA;
   logic [143:0]  memB;
   int            bad_count;
   int            total_checks;

   ddr_sep_io_sram_port i_dut (
      .clk(clk), .rst(rst), .inClockTrue(kTrue), .inClockComp(kComp),
      .dllEnable(dllEnable), .readSelN(readSelN), .writeSelN(writeSelN),
      .sync_address_bus(addr), .write_data_in(wData),
      .byte_write_mask_n(maskN), .read_data_out(rData),
      .read_data_oe(), .read_valid_out(rValid), .echo_clock_true(),
      .echo_clock_comp(), .dllLocked(dllLocked));
   host_model i_host (
      .clk(clk), .kTrue(kTrue), .kComp(kComp), .readSelN(readSelN),
      .writeSelN(writeSelN), .addr(addr), .data(wData), .maskN(maskN),
      .phase(phase));

   // ==========================================================
   // Helpers
   // ==========================================================
   task automatic check(input logic [35:0] got, input logic [35:0] exp,
                        input string what);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what,
                  got, exp);
      end
   endtask : check
   // Sample 2 ns after the edge, once the design has settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick
   function automatic logic [143:0] merge(input logic [143:0] old,
      input logic [143:0] nw, input logic [15:0] m);
      merge = old;
      for (int j = 0; j < 16; j++)
         if (!m[j]) merge[j*9 +: 9] = nw[j*9 +: 9];
   endfunction : merge
   task automatic beats(input int w, input logic [287:0] exp, input int n);
      tick(w);
      for (int i = 0; i < n; i++) begin
         check(rData, exp[i*36 +: 36], "read beat");
         check({35'h0, rValid}, 36'h1, "valid in burst");
         tick(4);
      end
      check({35'h0, rValid}, 36'h0, "valid after burst");
   endtask : beats
   task automatic idle(input int n);
      repeat (n) i_host.post(1'b0, 1'b0, '0, '0, '0);
   endtask : idle
   task automatic read_burst(input logic [17:0] a, input logic [143:0] e,
                             input int lat);
      i_host.post(1'b1, 1'b0, a, '0, '0);
      beats(8 * lat + 10, {144'h0, e}, 4);
   endtask : read_burst
   // Two idle slots let the last beat land before any read
   task automatic write_burst(input logic [17:0] a, input logic [143:0] d,
                              input logic [15:0] m);
      i_host.post(1'b0, 1'b1, a, d, m);
      idle(2);
   endtask : write_burst
   task automatic set_dll(input logic v);
      @(posedge clk);
      #1;
      dllEnable = v;
   endtask : set_dll

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic test_write_read();
      memA = {36'h9a5c3e1f0, 36'h12345678a, 36'hfedcba987, 36'h0f1e2d3c4};
      write_burst(ADDR_A, memA, 16'h0000);
      read_burst(ADDR_A, memA, LAT_DLL_ON);
      $display("test_write_read done");
   endtask : test_write_read
   task automatic test_byte_mask();
      logic [143:0] d;
      d    = {36'h111111111, 36'h222222222, 36'h333333333, 36'h444444444};
      memA = merge(memA, d, 16'h5f0e);
      write_burst(ADDR_A, d, 16'h5f0e);
      read_burst(ADDR_A, memA, LAT_DLL_ON);
      $display("test_byte_mask done");
   endtask : test_byte_mask
   task automatic test_seamless();
      memB = {36'h0c0ffee11, 36'h5a5a5a5a5, 36'ha5a5a5a5a, 36'h3c3c3c3c3};
      write_burst(ADDR_B, memB, 16'h0000);
      i_host.post(1'b1, 1'b0, ADDR_A, '0, '0);
      idle(1);
      i_host.post(1'b1, 1'b0, ADDR_B, '0, '0);
      beats(10, {memB, memA}, 8);
      $display("test_seamless done");
   endtask : test_seamless
   task automatic test_dll();
      set_dll(1'b0);
      tick(8);
      set_dll(1'b1);
      tick(8 * LOCK_KCYCLES - 40);
      check({35'h0, dllLocked}, 36'h0, "lock too early");
      tick(80);
      check({35'h0, dllLocked}, 36'h1, "lock missing");
      set_dll(1'b0);
      tick(8);
      check({35'h0, dllLocked}, 36'h0, "lock not cleared");
      read_burst(ADDR_B, memB, LAT_DLL_OFF);
      set_dll(1'b1);
      $display("test_dll done");
   endtask : test_dll

   // ==========================================================
   // Clock, sequence and verdict
   // ==========================================================
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results
   // Run needs about 9000 cycles; twice that means a hang
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      results();
   end
   initial begin
      bad_count    = 0;
      total_checks = 0;
      rst          = 1'b1;
      dllEnable    = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      tick(6);
      test_write_read();
      test_byte_mask();
      test_seamless();
      test_dll();
      results();
   end
endmodule : ddr_sep_io_sram_port_tb
`default_nettype wire
